// *** core/dcc_edge_latch.sv ***
/*
 latches a level on the falling edge of the timer clock, seen as a sampled input.
 assumes the timer clock is synchronous to the system clock.
*/
`timescale 1ns/10ps
module dcc_edge_latch (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_tmr_clk,
    input wire logic i_level,
    output logic o_latched
);
    logic tmr_clk_d;
    wire fall = tmr_clk_d & ~i_tmr_clk;
    // ----------------------------------------------------------------
    // falling edge capture; timer counts on the rise so no race
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            tmr_clk_d <= 1'b0;
            o_latched <= 1'b0;
        end else begin
            tmr_clk_d <= i_tmr_clk;
            if (fall) begin
                o_latched <= i_level; // R15
            end
        end
    end
endmodule : dcc_edge_latch

// *** core/dcc_pkg.sv ***
/*
 holds the shared constants of the dual comparator control block.
 assumes an 8-bit register port with read data one cycle after the read strobe.
*/
// Behaviour
// R01 - comparator b result reads at bit 7 of the config register, read only
// R02 - comparator a result reads at bit 6, its own inversion bit applies
// R03 - bit 5 inverts comparator b reported output when set
// R04 - bit 4 inverts comparator a reported output when set
// R05 - clear inversion gives low when minus exceeds plus; set swaps levels
// R06 - input switch routes inverting inputs only in modes 010 and 001
// R07 - in mode 010 a set switch puts comparator b minus on alternate pin
// R08 - three-bit mode field in bits 2-0 selects one of eight modes
// R09 - software should mask comparator interrupts while changing the mode
// R10 - gate source bit 1 set picks gate pin, clear picks comparator b; resets 1
// R11 - bit 0 set latches comparator b output on timer clock fall
// R12 - port bits of pins set as analog inputs read zero
// R13 - change flag sets when reported output changes; software sets or clears
// R14 - config access ends the mismatch; mismatch keeps setting the flag
// R15 - comparator b is latched after the prescaler on the falling timer edge
// R16 - reset returns both config registers to reset state, mode 000
// R17 - raw comparison results are synchronised before use
package dcc_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] DCC_ADDR_CONFIG = 8'h19;
    localparam logic [7:0] DCC_ADDR_GATE = 8'h1A;
    localparam logic [7:0] DCC_ADDR_IRQ_STATUS = 8'h20;
    localparam logic [7:0] DCC_ADDR_IRQ_CLEAR = 8'h21;
    localparam logic [7:0] DCC_ADDR_IRQ_ENABLE = 8'h22;
    localparam logic [7:0] DCC_ADDR_IRQ_SET = 8'h23;
    localparam logic [7:0] DCC_ADDR_PORT = 8'h24;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int DCC_BIT_B_RESULT = 7;
    localparam int DCC_BIT_A_RESULT = 6;
    localparam int DCC_BIT_B_INV = 5;
    localparam int DCC_BIT_A_INV = 4;
    localparam int DCC_BIT_SWITCH = 3;
    localparam int DCC_BIT_GATE_SEL = 1;
    localparam int DCC_BIT_SYNC_EN = 0;
    localparam int DCC_IRQ_A = 0;
    localparam int DCC_IRQ_B = 1;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [5:0] DCC_CONFIG_RESET = 6'h00;
    localparam logic [1:0] DCC_GATE_RESET = 2'h2;
    localparam logic [7:0] DCC_ZERO8 = 8'h00;
    // ----------------------------------------------------------------
    // comparator modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DCC_MODE_RESET = 3'b000,
        DCC_MODE_ONE_SW = 3'b001,
        DCC_MODE_DUAL_SW = 3'b010,
        DCC_MODE_3 = 3'b011,
        DCC_MODE_4 = 3'b100,
        DCC_MODE_5 = 3'b101,
        DCC_MODE_6 = 3'b110,
        DCC_MODE_OFF = 3'b111
    } dcc_mode_t;
endpackage : dcc_pkg

// *** core/dcc_sync2.sv ***
/*
 two-stage synchroniser for a single level.
 assumes the input may change at any time relative to the clock.
*/
`timescale 1ns/10ps
module dcc_sync2 (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_async,
    output logic o_sync
);
    logic stage1;
    // ----------------------------------------------------------------
    // first flop feeds only the second
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            stage1 <= i_async; // R17
            o_sync <= stage1;
        end
    end
endmodule : dcc_sync2

// *** core/dcc_top.sv ***
/*
 control and status logic for two analog comparators with timer gate output.
 assumes the register port master never strobes read and write together and
 that the prescaled timer clock is synchronous to the system clock.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
module dcc_top
    import dcc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_cmp_a_raw,
    input wire logic i_cmp_b_raw,
    input wire logic i_tmr_clk_presc,
    input wire logic i_timer_gate_pin,
    input wire logic [3:0] i_port_pins,
    input wire logic [3:0] i_pin_analog,
    output logic o_timer_gate,
    output logic o_cmp_a_minus_alt,
    output logic o_cmp_b_minus_alt,
    output logic [2:0] o_cmp_mode_field,
    output logic o_cmp_a_result,
    output logic o_cmp_b_result,
    output logic o_irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic cmp_a_invert;
    logic cmp_b_invert;
    logic input_switch_sel;
    dcc_mode_t cmp_mode_field;
    logic gate_source_sel;
    logic cmp_b_sync_en;
    logic [1:0] cmp_change_flag;
    logic [1:0] irq_enable;
    logic [1:0] last_result;
    logic [7:0] rdata;
    logic a_sync;
    logic b_sync;
    logic b_latched;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    wire wr_config = i_wr & hit(i_addr, DCC_ADDR_CONFIG);
    wire wr_gate = i_wr & hit(i_addr, DCC_ADDR_GATE);
    wire wr_clear = i_wr & hit(i_addr, DCC_ADDR_IRQ_CLEAR);
    wire wr_enable = i_wr & hit(i_addr, DCC_ADDR_IRQ_ENABLE);
    wire wr_set = i_wr & hit(i_addr, DCC_ADDR_IRQ_SET);
    wire acc_config = (i_wr | i_rd) & hit(i_addr, DCC_ADDR_CONFIG);

    // ----------------------------------------------------------------
    // synchronise raw results, then polarity
    // ----------------------------------------------------------------
    dcc_sync2 u_sync_a (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_async(i_cmp_a_raw),
        .o_sync(a_sync)
    );
    dcc_sync2 u_sync_b (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_async(i_cmp_b_raw),
        .o_sync(b_sync)
    );
    // raw high means plus exceeds minus; inversion swaps both levels
    wire res_a = a_sync ^ cmp_a_invert; // R04 R05
    wire res_b = b_sync ^ cmp_b_invert; // R03 R05
    wire [1:0] result_now = {res_b, res_a};

    // ----------------------------------------------------------------
    // optional latch of comparator b for the timer gate
    // ----------------------------------------------------------------
    dcc_edge_latch u_latch_b (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_tmr_clk(i_tmr_clk_presc),
        .i_level(res_b),
        .o_latched(b_latched)
    );
    wire b_for_gate = cmp_b_sync_en ? b_latched : res_b; // R11
    wire next_gate = gate_source_sel ? i_timer_gate_pin : b_for_gate; // R10

    // ----------------------------------------------------------------
    // inverting input routing
    // ----------------------------------------------------------------
    wire mode_dual = (cmp_mode_field == DCC_MODE_DUAL_SW);
    wire mode_one = (cmp_mode_field == DCC_MODE_ONE_SW);
    wire next_a_alt = (mode_dual | mode_one) & input_switch_sel; // R06
    wire next_b_alt = mode_dual & input_switch_sel; // R06 R07

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            {cmp_b_invert, cmp_a_invert, input_switch_sel} <= DCC_CONFIG_RESET[5:3]; // R16
            cmp_mode_field <= DCC_MODE_RESET; // R16
        end else if (wr_config) begin
            cmp_b_invert <= i_wdata[DCC_BIT_B_INV]; // R03
            cmp_a_invert <= i_wdata[DCC_BIT_A_INV]; // R04
            input_switch_sel <= i_wdata[DCC_BIT_SWITCH];
            cmp_mode_field <= dcc_mode_t'(i_wdata[2:0]); // R08
        end
    end

    // gate config resets with the gate pin selected
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            {gate_source_sel, cmp_b_sync_en} <= DCC_GATE_RESET; // R10 R16
        end else if (wr_gate) begin
            gate_source_sel <= i_wdata[DCC_BIT_GATE_SEL];
            cmp_b_sync_en <= i_wdata[DCC_BIT_SYNC_EN];
        end
    end

    // ----------------------------------------------------------------
    // mismatch and change flags
    // ----------------------------------------------------------------
    // reference only moves on a config access, so mismatch persists
    wire [1:0] mismatch = result_now ^ last_result;
    wire [1:0] next_flag = (cmp_change_flag & ~({2{wr_clear}} & i_wdata[1:0]))
        | ({2{wr_set}} & i_wdata[1:0]) | mismatch; // R13 R14

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            last_result <= 2'b00;
            cmp_change_flag <= 2'b00;
            irq_enable <= 2'b00;
        end else begin
            if (acc_config) begin
                last_result <= result_now; // R14
            end
            cmp_change_flag <= next_flag; // R13
            if (wr_enable) begin
                irq_enable <= i_wdata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [7:0] rd_config = {res_b, res_a, cmp_b_invert, cmp_a_invert,
        input_switch_sel, cmp_mode_field}; // R01 R02
    wire [7:0] rd_gate = {6'h00, gate_source_sel, cmp_b_sync_en};
    wire [7:0] rd_port = {4'h0, i_port_pins & ~i_pin_analog}; // R12
    wire [7:0] rd_sel =
        hit(i_addr, DCC_ADDR_CONFIG) ? rd_config :
        hit(i_addr, DCC_ADDR_GATE) ? rd_gate :
        hit(i_addr, DCC_ADDR_IRQ_STATUS) ? {6'h00, cmp_change_flag} :
        hit(i_addr, DCC_ADDR_IRQ_ENABLE) ? {6'h00, irq_enable} :
        hit(i_addr, DCC_ADDR_PORT) ? rd_port : DCC_ZERO8;

    // read data only in the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rdata <= DCC_ZERO8;
        end else begin
            rdata <= i_rd ? rd_sel : DCC_ZERO8;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_timer_gate <= 1'b0;
            o_cmp_a_minus_alt <= 1'b0;
            o_cmp_b_minus_alt <= 1'b0;
            o_cmp_a_result <= 1'b0;
            o_cmp_b_result <= 1'b0;
        end else begin
            o_timer_gate <= next_gate;
            o_cmp_a_minus_alt <= next_a_alt;
            o_cmp_b_minus_alt <= next_b_alt;
            o_cmp_a_result <= res_a;
            o_cmp_b_result <= res_b;
        end
    end

    assign o_rdata = rdata;
    assign o_cmp_mode_field = cmp_mode_field; // R08
    // software is expected to mask this while changing modes
    assign o_irq = |(cmp_change_flag & irq_enable); // R09

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    result_b_read_a: assert property (i_rd && hit(i_addr, DCC_ADDR_CONFIG) // R01
        |=> o_rdata[DCC_BIT_B_RESULT] == $past(res_b)) else $error("b result read wrong");
    result_a_read_a: assert property (i_rd && hit(i_addr, DCC_ADDR_CONFIG) // R02
        |=> o_rdata[DCC_BIT_A_RESULT] == $past(a_sync ^ cmp_a_invert))
        else $error("a result read wrong");
    // watch the registered result pin, not the xor that feeds it
    invert_b_a: assert property (cmp_b_invert |=> o_cmp_b_result == !$past(b_sync)) // R03
        else $error("b polarity wrong");
    invert_a_a: assert property (!cmp_a_invert |=> o_cmp_a_result == $past(a_sync)) // R05
        else $error("a polarity wrong");
    route_b_a: assert property ( // R07
        ##1 o_cmp_b_minus_alt == $past(mode_dual && input_switch_sel))
        else $error("b route wrong");
    route_a_a: assert property (cmp_mode_field == DCC_MODE_ONE_SW && input_switch_sel // R06
        |=> o_cmp_a_minus_alt) else $error("a route wrong");
    mode_write_a: assert property (wr_config |=> cmp_mode_field == $past(i_wdata[2:0])) // R08
        else $error("mode not written");
    gate_pin_a: assert property (gate_source_sel // R10
        |=> o_timer_gate == $past(i_timer_gate_pin)) else $error("gate source wrong");
    flag_set_a: assert property (mismatch[DCC_IRQ_B] |=> cmp_change_flag[DCC_IRQ_B]) // R13
        else $error("flag not set on change");
    flag_hold_a: assert property (cmp_change_flag[DCC_IRQ_A] && !wr_clear // R13
        |=> cmp_change_flag[DCC_IRQ_A]) else $error("flag lost");
    mismatch_end_a: assert property (acc_config |=> last_result == $past(result_now)) // R14
        else $error("mismatch not ended");
    port_analog_a: assert property (i_rd && hit(i_addr, DCC_ADDR_PORT) && i_pin_analog[0] // R12
        |=> !o_rdata[0]) else $error("analog pin read nonzero");
    reset_gate_a: assert property (@(posedge i_sys_clk) disable iff (1'b0) // R16
        i_srst |=> gate_source_sel && !cmp_b_sync_en && cmp_mode_field == DCC_MODE_RESET)
        else $error("reset state wrong");
    sync_b_a: assert property (cmp_b_sync_en && !gate_source_sel && $stable(b_latched) // R11
        |=> o_timer_gate == $past(b_latched)) else $error("sync gate wrong");

    irq_raise_c: cover property (mismatch != 2'b00 ##1 o_irq);
    clear_c: cover property (wr_clear ##1 cmp_change_flag == 2'b00);
    sync_gate_c: cover property (cmp_b_sync_en && !gate_source_sel ##1 $changed(o_timer_gate));
    dual_route_c: cover property (o_cmp_b_minus_alt);
endmodule : dcc_top

// *** sim/dcc_front_model.sv ***
/*
 model of the two analog comparator front ends and the prescaled timer clock.
 assumes the bench commands which input is higher, on the 100 MHz system clock.
*/
`timescale 1ns/10ps
module dcc_front_model (
    input wire logic i_sys_clk,
    input wire logic i_a_above,
    input wire logic i_b_above,
    input wire logic i_tclk_run,
    output logic o_cmp_a_raw,
    output logic o_cmp_b_raw,
    output logic o_tmr_clk
);
    // ----------------------------------------------------------------
    // analog results
    // ----------------------------------------------------------------
    logic [1:0] div = 2'h0;
    // high while plus exceeds minus; the lag keeps edges off the clock
    assign #3 o_cmp_a_raw = i_a_above;
    assign #3 o_cmp_b_raw = i_b_above;
    // ----------------------------------------------------------------
    // timer clock
    // ----------------------------------------------------------------
    // divide by four; stands still when stopped so latching can be held off
    always @(posedge i_sys_clk) begin
        if (i_tclk_run) begin
            div <= div + 2'h1;
        end
    end
    assign o_tmr_clk = div[1];
endmodule : dcc_front_model

// *** sim/test_dcc_top.sv ***
/*
 self-checking bench for the dual comparator control block.
 assumes the register port map and latencies of the block's package.
*/
`timescale 1ns/10ps
module test_dcc_top;
    import dcc_pkg::*;
    // ----------------------------------------------------------------
    // signals and design
    // ----------------------------------------------------------------
    typedef struct {logic [7:0] cfg; logic a, b, ra, rb; logic [1:0] alt;} dcc_row_t;
    logic i_sys_clk = 1'b0;
    logic i_srst, i_wr, i_rd, i_timer_gate_pin, a_above, b_above, run;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic [3:0] i_port_pins, i_pin_analog;
    logic raw_a, raw_b, tclk, o_timer_gate, o_irq, o_cmp_a_result, o_cmp_b_result;
    logic alt_a, alt_b;
    logic [2:0] o_cmp_mode_field;
    int mismatches = 0;
    int checks_done = 0;
    // mode, polarity and routing cases; results already folded through inversion
    dcc_row_t rows [9] = '{
        '{8'hC2, 1, 0, 1, 0, 2'h0}, '{8'h0A, 0, 1, 0, 1, 2'h3}, '{8'h09, 1, 1, 1, 1, 2'h1},
        '{8'h01, 0, 0, 0, 0, 2'h0}, '{8'h13, 1, 1, 0, 1, 2'h0}, '{8'h24, 0, 1, 0, 0, 2'h0},
        '{8'h35, 0, 0, 1, 1, 2'h0}, '{8'h36, 1, 0, 0, 1, 2'h0}, '{8'h07, 1, 0, 1, 0, 2'h0}};
    always #5 i_sys_clk = ~i_sys_clk;
    dcc_front_model i_front (.i_sys_clk(i_sys_clk), .i_a_above(a_above),
        .i_b_above(b_above), .i_tclk_run(run), .o_cmp_a_raw(raw_a),
        .o_cmp_b_raw(raw_b), .o_tmr_clk(tclk));
    dcc_top i_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_cmp_a_raw(raw_a), .i_cmp_b_raw(raw_b), .i_tmr_clk_presc(tclk),
        .i_timer_gate_pin(i_timer_gate_pin), .i_port_pins(i_port_pins),
        .i_pin_analog(i_pin_analog), .o_timer_gate(o_timer_gate),
        .o_cmp_a_minus_alt(alt_a), .o_cmp_b_minus_alt(alt_b),
        .o_cmp_mode_field(o_cmp_mode_field), .o_cmp_a_result(o_cmp_a_result),
        .o_cmp_b_result(o_cmp_b_result), .o_irq(o_irq));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 check(o_rdata, exp);
    endtask : rd_chk
    // raw levels need sync stages plus the output register
    task automatic settle;
        repeat (6) @(posedge i_sys_clk);
        #1;
    endtask : settle
    task automatic pulse_reset;
        i_srst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_srst <= 1'b0;
    endtask : pulse_reset
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        {i_wr, i_rd, i_timer_gate_pin, a_above, b_above, run} = 6'h00;
        {i_addr, i_wdata} = 16'h0000;
        i_port_pins = 4'hF;
        i_pin_analog = 4'h5;
        pulse_reset();
        rd_chk(DCC_ADDR_CONFIG, 8'h00);
        rd_chk(DCC_ADDR_GATE, 8'h02);
        wr_reg(DCC_ADDR_IRQ_ENABLE, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr_reg(DCC_ADDR_CONFIG, rows[i].cfg);
            a_above <= rows[i].a;
            b_above <= rows[i].b;
            settle();
            check({6'h00, o_cmp_b_result, o_cmp_a_result}, {6'h00, rows[i].rb, rows[i].ra});
            check({5'h00, o_cmp_mode_field}, {5'h00, rows[i].cfg[2:0]});
            if (rows[i].cfg[2:0] inside {3'b001, 3'b010}) begin
                check({6'h00, alt_b, alt_a}, {6'h00, rows[i].alt});
            end
            rd_chk(DCC_ADDR_CONFIG, {rows[i].rb, rows[i].ra, rows[i].cfg[5:0]});
        end
        // gate from pin, then from comparator b, then latched on timer fall
        wr_reg(DCC_ADDR_CONFIG, 8'h00);
        i_timer_gate_pin <= 1'b1;
        settle();
        check({7'h00, o_timer_gate}, 8'h01);
        wr_reg(DCC_ADDR_GATE, 8'h00);
        // pin stays high, so a low gate shows comparator b took over
        b_above <= 1'b0;
        settle();
        check({7'h00, o_timer_gate}, 8'h00);
        a_above <= 1'b0;
        wr_reg(DCC_ADDR_GATE, 8'h01);
        b_above <= 1'b0;
        settle();
        b_above <= 1'b1;
        settle();
        check({7'h00, o_timer_gate}, 8'h00);
        run <= 1'b1;
        repeat (12) @(posedge i_sys_clk);
        #1 check({7'h00, o_timer_gate}, 8'h01);
        // change flags, mismatch hold, software set and masking
        wr_reg(DCC_ADDR_IRQ_ENABLE, 8'h03);
        rd_chk(DCC_ADDR_CONFIG, 8'h80);
        wr_reg(DCC_ADDR_IRQ_CLEAR, 8'h03);
        rd_chk(DCC_ADDR_IRQ_STATUS, 8'h00);
        @(posedge i_sys_clk);
        a_above <= 1'b1;
        @(posedge i_sys_clk);
        #1 check({7'h00, o_cmp_a_result}, 8'h00);
        settle();
        check({7'h00, o_irq}, 8'h01);
        rd_chk(DCC_ADDR_IRQ_STATUS, 8'h01);
        wr_reg(DCC_ADDR_IRQ_CLEAR, 8'h01);
        rd_chk(DCC_ADDR_IRQ_STATUS, 8'h01);
        wr_reg(DCC_ADDR_CONFIG, 8'h00);
        wr_reg(DCC_ADDR_IRQ_CLEAR, 8'h01);
        rd_chk(DCC_ADDR_IRQ_STATUS, 8'h00);
        check({7'h00, o_irq}, 8'h00);
        wr_reg(DCC_ADDR_IRQ_SET, 8'h02);
        rd_chk(DCC_ADDR_IRQ_STATUS, 8'h02);
        check({7'h00, o_irq}, 8'h01);
        wr_reg(DCC_ADDR_IRQ_ENABLE, 8'h01);
        #1 check({7'h00, o_irq}, 8'h00);
        // port masking and an unmapped place
        rd_chk(DCC_ADDR_PORT, 8'h0A);
        rd_chk(8'h30, 8'h00);
        // reset in mid-run with settings changed
        wr_reg(DCC_ADDR_CONFIG, 8'h3A);
        wr_reg(DCC_ADDR_GATE, 8'h01);
        {a_above, b_above} <= 2'b00;
        settle();
        pulse_reset();
        rd_chk(DCC_ADDR_CONFIG, 8'h00);
        rd_chk(DCC_ADDR_GATE, 8'h02);
        check({7'h00, o_irq}, 8'h00);
        final_report();
    end
    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
endmodule : test_dcc_top
